// ---- rtl/bcd_clock_calendar_ctrl.sv ----
// bcd clock and calendar with alarm, write lock and drift trim, behind an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"

module bcd_clock_calendar_ctrl #(
  parameter int XTAL_HZ = `RTC_XTAL_HZ
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // crystal and output pin
  input  wire logic        xtal_in,
  output logic             pin_out,
  output logic             pin_oe
);

  localparam logic signed [18:0] PRE_LAST = 19'(XTAL_HZ - 1);
  localparam logic signed [18:0] PRE_HALF = 19'(XTAL_HZ / 2);
  localparam logic signed [18:0] PRE_SYNC = 19'(XTAL_HZ - `RTC_SYNC_TICKS);
  localparam logic [3:0]         UNL_CYC  = 4'(`RTC_UNLOCK_CYC);

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] >= 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0} : {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction : bcd_inc

  function automatic logic [1:0] ptr_dec(input logic [1:0] p);
    ptr_dec = (p == 2'b00) ? 2'b00 : 2'(p - 2'b01);
  endfunction : ptr_dec

  // every fourth year in bcd, 2000 included
  function automatic logic [7:0] last_day(input logic [7:0] mth, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    unique case (mth)
      `RTC_FEB:                      last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11:    last_day = 8'h30;
      default:                       last_day = 8'h31;
    endcase
  endfunction : last_day

  // >= comparisons keep a bad software value from running away
  function automatic rtc_pkg::time_t advance(input rtc_pkg::time_t t);
    rtc_pkg::time_t r;
    r = t;
    if (t.sec >= `RTC_LAST_SEC)
    begin
      r.sec = 8'h00;
      if (t.min >= `RTC_LAST_SEC)
      begin
        r.min = 8'h00;
        if (t.hr >= `RTC_LAST_HR)
        begin
          r.hr   = 8'h00;
          r.wday = (t.wday >= `RTC_LAST_WDAY) ? 8'h00 : bcd_inc(t.wday);
          if (t.day >= last_day(t.mth, t.yr))
          begin
            r.day = `RTC_FIRST_DAY;
            if (t.mth >= `RTC_LAST_MTH)
            begin
              r.mth = `RTC_FIRST_DAY;
              r.yr  = (t.yr >= `RTC_LAST_YR) ? 8'h00 : bcd_inc(t.yr);
            end
            else
              r.mth = bcd_inc(t.mth);
          end
          else
            r.day = bcd_inc(t.day);
        end
        else
          r.hr = bcd_inc(t.hr);
      end
      else
        r.min = bcd_inc(t.min);
    end
    else
      r.sec = bcd_inc(t.sec);
    advance = r;
  endfunction : advance

  // state
  rtc_pkg::clk_cfg_t   cfg_r;
  rtc_pkg::alarm_cfg_t alcfg_r;
  rtc_pkg::time_t      time_r;
  rtc_pkg::time_t      alval_r;
  rtc_pkg::key_state_t key_r;
  logic [3:0]          unl_cnt_r;
  logic                src_sel_r;
  logic signed [18:0]  pre_r;
  logic [2:0]          xs_r;
  logic                chk_r;
  logic                alarm_pulse_r;
  logic                pin_out_r;
  logic                dp_wr_r;
  logic [7:0]          dp_addr_r;
  logic [31:0]         rdata_r;

  // bus decode
  wire        ap_take   = hsel && htrans[1] && hready;
  wire        ap_rd     = ap_take && !hwrite;
  wire        wr_en     = dp_wr_r;
  wire [15:0] wd        = hwdata[15:0];
  wire        wr_cfg    = wr_en && dp_addr_r == `RTC_OFF_CFG;
  wire        wr_pad    = wr_en && dp_addr_r == `RTC_OFF_PAD;
  wire        wr_time   = wr_en && dp_addr_r == `RTC_OFF_TIME;
  wire        wr_alcfg  = wr_en && dp_addr_r == `RTC_OFF_ALCFG;
  wire        wr_alval  = wr_en && dp_addr_r == `RTC_OFF_ALVAL;
  wire        wr_key    = wr_en && dp_addr_r == `RTC_OFF_KEY;
  wire        rd_time   = ap_rd && haddr == `RTC_OFF_TIME;
  wire        rd_alval  = ap_rd && haddr == `RTC_OFF_ALVAL;
  wire        time_ok   = wr_time && cfg_r.wren;

  // crystal timing
  wire        xtal_rise = xs_r[1] && !xs_r[2];
  wire        tick      = cfg_r.en && xtal_rise;
  wire        sec_tick  = tick && pre_r >= PRE_LAST;
  wire        half_tick = tick && pre_r == PRE_HALF - 19'sd1;
  wire        half_flag = pre_r >= PRE_HALF;
  wire        sync_flag = cfg_r.en && pre_r >= PRE_SYNC;
  wire        min_roll  = time_r.sec >= `RTC_LAST_SEC;
  wire signed [18:0] cal_start = {{9{cfg_r.cal[7]}}, cfg_r.cal, 2'b00};

  // alarm compare against the freshly advanced time
  wire        eq_s1  = time_r.sec[3:0] == alval_r.sec[3:0];
  wire        eq_s   = time_r.sec == alval_r.sec;
  wire        eq_m1  = time_r.min[3:0] == alval_r.min[3:0];
  wire        eq_ms  = eq_s && time_r.min == alval_r.min;
  wire        eq_hms = eq_ms && time_r.hr == alval_r.hr;
  wire        eq_dom = eq_hms && time_r.day == alval_r.day;
  logic       match;
  always_comb
  begin
    unique case (alcfg_r.mask)
      4'h0:    match = 1'b1;
      4'h1:    match = 1'b1;
      4'h2:    match = eq_s1;
      4'h3:    match = eq_s;
      4'h4:    match = eq_s && eq_m1;
      4'h5:    match = eq_ms;
      4'h6:    match = eq_hms;
      4'h7:    match = eq_hms && time_r.wday == alval_r.wday;
      4'h8:    match = eq_dom;
      4'h9:    match = eq_dom && time_r.mth == alval_r.mth;
      default: match = 1'b0;
    endcase
  end
  // the half-second code also fires at the mid-second point
  wire alarm_event = alcfg_r.en && match && (chk_r || (alcfg_r.mask == 4'h0 && half_tick));

  // read multiplexers
  logic [15:0] time_win;
  logic [15:0] alarm_win;
  always_comb
  begin
    unique case (cfg_r.ptr)
      2'b00: time_win = {time_r.min, time_r.sec};
      2'b01: time_win = {time_r.wday, time_r.hr};
      2'b10: time_win = {time_r.mth, time_r.day};
      2'b11: time_win = {8'h00, time_r.yr};
    endcase
    unique case (alcfg_r.ptr)
      2'b00: alarm_win = {alval_r.min, alval_r.sec};
      2'b01: alarm_win = {alval_r.wday, alval_r.hr};
      2'b10: alarm_win = {alval_r.mth, alval_r.day};
      2'b11: alarm_win = 16'h0000;
    endcase
  end
  wire [15:0] cfg_word = {cfg_r.en, 1'b0, cfg_r.wren, sync_flag, half_flag, cfg_r.oe, cfg_r.ptr, cfg_r.cal};
  logic [15:0] rd_word;
  always_comb
  begin
    unique case (haddr)
      `RTC_OFF_CFG:   rd_word = cfg_word;
      `RTC_OFF_PAD:   rd_word = {14'h0000, src_sel_r, 1'b0};
      `RTC_OFF_TIME:  rd_word = time_win;
      `RTC_OFF_ALCFG: rd_word = alcfg_r;
      `RTC_OFF_ALVAL: rd_word = alarm_win;
      default:        rd_word = 16'h0000;
    endcase
  end

  assign hrdata    = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign pin_out   = pin_out_r;
  assign pin_oe    = cfg_r.oe;

  // bus pipeline
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      dp_wr_r   <= ap_take && hwrite;
      dp_addr_r <= haddr;
      if (ap_rd)
        rdata_r <= {16'h0000, rd_word};
    end
  end

  // unlock sequence; the open window is spent by the very next write
  rtc_pkg::key_state_t key_nxt;
  always_comb
  begin
    key_nxt = key_r;
    if (wr_key)
      key_nxt = (wd[7:0] == `RTC_KEY_FIRST) ? rtc_pkg::KEY_ARMED
              : (key_r == rtc_pkg::KEY_ARMED && wd[7:0] == `RTC_KEY_SECOND) ? rtc_pkg::KEY_OPEN
              : rtc_pkg::KEY_IDLE;
    else if (key_r == rtc_pkg::KEY_OPEN && (wr_en || unl_cnt_r == 4'h0))
      key_nxt = rtc_pkg::KEY_IDLE;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_r     <= rtc_pkg::KEY_IDLE;
      unl_cnt_r <= 4'h0;
    end
    else
    begin
      key_r     <= key_nxt;
      unl_cnt_r <= (key_nxt == rtc_pkg::KEY_OPEN && key_r != rtc_pkg::KEY_OPEN) ? UNL_CYC
                 : (unl_cnt_r != 4'h0) ? 4'(unl_cnt_r - 4'h1) : 4'h0;
    end
  end

  // configuration and trim register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_r     <= '0;
      src_sel_r <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
      begin
        if (cfg_r.wren)
          cfg_r.en <= wd[`RTC_CFG_EN];
        cfg_r.wren <= wd[`RTC_CFG_WREN] && (cfg_r.wren || key_r == rtc_pkg::KEY_OPEN);
        cfg_r.oe   <= wd[`RTC_CFG_OE];
        cfg_r.ptr  <= wd[9:8];
        cfg_r.cal  <= wd[7:0];
      end
      else if (wr_time || rd_time)
        cfg_r.ptr <= ptr_dec(cfg_r.ptr);
      if (wr_pad)
        src_sel_r <= wd[`RTC_PAD_SEL];
    end
  end

  // crystal synchroniser, prescaler with per-minute trim
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      xs_r  <= 3'b000;
      pre_r <= 19'sd0;
    end
    else
    begin
      xs_r <= {xs_r[1:0], xtal_in};
      if (time_ok && cfg_r.ptr == 2'b00)
        pre_r <= 19'sd0;
      else if (sec_tick)
        pre_r <= min_roll ? cal_start : 19'sd0;
      else if (tick)
        pre_r <= 19'(pre_r + 19'sd1);
    end
  end

  // time fields; a software write wins over a same-cycle second carry
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      time_r     <= '0;
      time_r.day <= `RTC_FIRST_DAY;
      time_r.mth <= `RTC_FIRST_DAY;
    end
    else if (time_ok)
    begin
      unique case (cfg_r.ptr)
        2'b00:
        begin
          time_r.min <= wd[15:8] & `RTC_MASK_SEC;
          time_r.sec <= wd[7:0] & `RTC_MASK_SEC;
        end
        2'b01:
        begin
          time_r.wday <= wd[15:8] & `RTC_MASK_WDAY;
          time_r.hr   <= wd[7:0] & `RTC_MASK_HR;
        end
        2'b10:
        begin
          time_r.mth <= wd[15:8] & `RTC_MASK_MTH;
          time_r.day <= wd[7:0] & `RTC_MASK_DAY;
        end
        2'b11: time_r.yr <= wd[7:0] & `RTC_MASK_YR;
      endcase
    end
    else if (sec_tick)
      time_r <= advance(time_r);
  end

  // alarm configuration and values
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alcfg_r <= '0;
      alval_r <= '0;
    end
    else
    begin
      if (wr_alcfg)
        alcfg_r <= wd;
      else
      begin
        if (alarm_event)
        begin
          if (alcfg_r.rpt != 8'h00)
            alcfg_r.rpt <= 8'(alcfg_r.rpt - 8'h01);
          else if (alcfg_r.chime)
            alcfg_r.rpt <= 8'hff;
          else
            alcfg_r.en <= 1'b0;
        end
        if (wr_alval || rd_alval)
          alcfg_r.ptr <= ptr_dec(alcfg_r.ptr);
      end
      if (wr_alval)
      begin
        unique case (alcfg_r.ptr)
          2'b00:
          begin
            alval_r.min <= wd[15:8] & `RTC_MASK_SEC;
            alval_r.sec <= wd[7:0] & `RTC_MASK_SEC;
          end
          2'b01:
          begin
            alval_r.wday <= wd[15:8] & `RTC_MASK_WDAY;
            alval_r.hr   <= wd[7:0] & `RTC_MASK_HR;
          end
          2'b10:
          begin
            alval_r.mth <= wd[15:8] & `RTC_MASK_MTH;
            alval_r.day <= wd[7:0] & `RTC_MASK_DAY;
          end
          2'b11: alval_r.yr <= alval_r.yr;
        endcase
      end
    end
  end

  // alarm pulse lasts until the next half-second or whole-second point, whichever comes first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      chk_r         <= 1'b0;
      alarm_pulse_r <= 1'b0;
      pin_out_r     <= 1'b0;
    end
    else
    begin
      chk_r         <= sec_tick;
      alarm_pulse_r <= alarm_event || (alarm_pulse_r && !half_tick && !sec_tick);
      pin_out_r     <= cfg_r.oe && (src_sel_r ? (cfg_r.en && !half_flag) : alarm_pulse_r);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  time_ptr_dec_a: assert property ((wr_time && cfg_r.ptr != 2'b00) |=> cfg_r.ptr == $past(cfg_r.ptr) - 2'b01)
    else $error("time pointer did not step down");
  alarm_ptr_hold_a: assert property ((rd_alval && alcfg_r.ptr == 2'b00 && !wr_alcfg) |=> alcfg_r.ptr == 2'b00)
    else $error("alarm pointer left zero");
  time_lock_a: assert property ((wr_time && !cfg_r.wren && !sec_tick) |=> $stable(time_r))
    else $error("locked time write took effect");
  unlock_gate_a: assert property ($rose(cfg_r.wren) |-> $past(key_r) == rtc_pkg::KEY_OPEN)
    else $error("unlock bit set outside key window");
  enable_lock_a: assert property ((wr_cfg && !cfg_r.wren) |=> $stable(cfg_r.en))
    else $error("enable changed while locked");
  half_clear_a: assert property (sec_tick |=> !half_flag ##0 !sync_flag)
    else $error("half flag or sync flag high after rollover");
  pin_off_a: assert property (!cfg_r.oe |=> !pin_out_r)
    else $error("pin driven while output disabled");
  alarm_stop_a: assert property ((alarm_event && alcfg_r.rpt == 8'h00 && !alcfg_r.chime && !wr_alcfg)
    |=> !alcfg_r.en)
    else $error("alarm enable did not self clear");
  chime_wrap_a: assert property ((alarm_event && alcfg_r.rpt == 8'h00 && alcfg_r.chime && !wr_alcfg)
    |=> alcfg_r.rpt == 8'hff)
    else $error("repeat count did not wrap");
  weekday_wrap_a: assert property ((sec_tick && !time_ok && time_r.wday == 8'h06 && time_r.sec == 8'h59
    && time_r.min == 8'h59 && time_r.hr == 8'h23) |=> time_r.wday == 8'h00)
    else $error("weekday did not wrap");

endmodule : bcd_clock_calendar_ctrl

`default_nettype wire

// ---- rtl/rtc_pkg.sv ----
// types shared by the clock and calendar unit
package rtc_pkg;

  typedef struct packed {
    logic [7:0] yr;
    logic [7:0] mth;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] hr;
    logic [7:0] min;
    logic [7:0] sec;
  } time_t;

  // same bit layout as the alarm configuration word
  typedef struct packed {
    logic       en;
    logic       chime;
    logic [3:0] mask;
    logic [1:0] ptr;
    logic [7:0] rpt;
  } alarm_cfg_t;

  typedef struct packed {
    logic       en;
    logic       wren;
    logic       oe;
    logic [1:0] ptr;
    logic [7:0] cal;
  } clk_cfg_t;

  typedef enum logic [2:0] {
    KEY_IDLE  = 3'b001,
    KEY_ARMED = 3'b010,
    KEY_OPEN  = 3'b100
  } key_state_t;

endpackage : rtc_pkg

// ---- rtl/rtc_regs.svh ----
// register offsets, field positions and timing constants for the clock and calendar unit
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

`define RTC_OFF_CFG        8'h00
`define RTC_OFF_PAD        8'h04
`define RTC_OFF_TIME       8'h08
`define RTC_OFF_ALCFG      8'h0c
`define RTC_OFF_ALVAL      8'h10
`define RTC_OFF_KEY        8'h14

`define RTC_CFG_EN         15
`define RTC_CFG_WREN       13
`define RTC_CFG_SYNC       12
`define RTC_CFG_HALF       11
`define RTC_CFG_OE         10
`define RTC_PAD_SEL        1

`define RTC_KEY_FIRST      8'h55
`define RTC_KEY_SECOND     8'haa

`define RTC_XTAL_HZ        32768
`define RTC_SYNC_TICKS     32
`define RTC_UNLOCK_CYC     8
`define RTC_CAL_SHIFT      2

`define RTC_MASK_SEC       8'h7f
`define RTC_MASK_HR        8'h3f
`define RTC_MASK_WDAY      8'h07
`define RTC_MASK_DAY       8'h3f
`define RTC_MASK_MTH       8'h1f
`define RTC_MASK_YR        8'hff

`define RTC_LAST_SEC       8'h59
`define RTC_LAST_HR        8'h23
`define RTC_LAST_WDAY      8'h06
`define RTC_LAST_MTH       8'h12
`define RTC_LAST_YR        8'h99
`define RTC_FIRST_DAY      8'h01
`define RTC_FEB            8'h02

`endif

// ---- sim/bcd_clock_calendar_ctrl_tb_top.sv ----
// self-checking bench for the bcd clock and calendar unit
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"
module bcd_clock_calendar_ctrl_tb_top;
  // shortened crystal count; the crystal toggles every 4 clocks, so one second is XT*8 clocks
  localparam int         XT  = 128;
  localparam int         SEC = XT * 8;
  localparam logic [7:0] CFG = `RTC_OFF_CFG;
  localparam logic [7:0] PAD = `RTC_OFF_PAD;
  localparam logic [7:0] TIM = `RTC_OFF_TIME;
  localparam logic [7:0] ACF = `RTC_OFF_ALCFG;
  localparam logic [7:0] AVL = `RTC_OFF_ALVAL;
  localparam logic [7:0] KEY = `RTC_OFF_KEY;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  wire logic   hready;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        xtal_in = 1'b0;
  logic        pin_out;
  logic        pin_oe;
  logic [2:0]  xc      = 3'h0;
  logic [31:0] q;
  logic [31:0] lf;
  int          fail_count;
  int          total_checks;

  assign hready = hreadyout;

  bcd_clock_calendar_ctrl #(.XTAL_HZ(XT)) bcd_clock_calendar_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .xtal_in(xtal_in), .pin_out(pin_out), .pin_oe(pin_oe)
  );

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // crystal stand-in, far slower than hclk so the synchroniser sees every edge
  always @(posedge hclk)
  begin
    xc <= xc + 3'h1;
    xtal_in <= xc[2];
  end

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : bcd

  // events in one alarm step after xx:59:59: half-second code sees two, masks 1 to 5 one
  function automatic int fire(input logic [15:0] c);
    if (!c[15])
      return 0;
    return (c[13:10] == 4'h0) ? 2 : (c[13:10] inside {[4'h1:4'h5]}) ? 1 : 0;
  endfunction : fire

  function automatic logic [15:0] aexp(input logic [15:0] c);
    logic [15:0] r;
    r = c;
    repeat (fire(c))
    begin
      if (r[15] && r[7:0] == 8'h00)
      begin
        r[15]  = r[14];
        r[7:0] = {8{r[14]}};
      end
      else if (r[15])
        r[7:0] = r[7:0] - 8'h01;
    end
    return r;
  endfunction : aexp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {16'h0000, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
  endtask : rd

  task automatic tk(input int n);
    repeat (n) @(posedge hclk);
  endtask : tk

  task automatic unlock(input logic brk, input logic [15:0] d);
    wr(KEY, {8'h00, `RTC_KEY_FIRST});
    wr(KEY, {8'h00, `RTC_KEY_SECOND});
    if (brk)
      wr(PAD, 16'h0000);
    wr(CFG, d);
  endtask : unlock

  // load a pointer, write four values, wait, reload and read five back
  task automatic win(input logic [7:0] ca, input logic [7:0] wa, input logic [15:0] cw,
                     input logic [15:0] v[4], input int w, input logic [15:0] rw,
                     input logic [15:0] e[5]);
    wr(ca, cw);
    foreach (v[i]) wr(wa, v[i]);
    tk(w);
    wr(ca, rw);
    foreach (e[i]) rd(wa, e[i]);
  endtask : win

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #(4 * 40000);
    fail_count++;
    report_and_stop;
  end

  initial
  begin
    logic [7:0]  y;
    logic [15:0] c;
    logic [7:0]  yl[2];
    logic [15:0] md[2];
    logic [7:0]  at[8];
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    fail_count = 0;
    total_checks = 0;
    lf = 32'ha0997c30;
    yl = '{8'h24, 8'h23};
    md = '{16'h0229, 16'h0301};
    at = '{8'h84, 8'h88, 8'hcc, 8'h90, 8'ha8, 8'hc0, 8'h94, 8'h98};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CFG, 16'h0000);
    rd(PAD, 16'h0000);
    rd(ACF, 16'h0000);
    rd(KEY, 16'h0000);
    rd(8'h18, 16'h0000);
    rd(TIM, 16'h0000);
    chk(32'(pin_oe), 32'h0);
    $display("test reset done");
    wr(CFG, 16'ha000);
    rd(CFG, 16'h0000);
    wr(TIM, 16'h1234);
    rd(TIM, 16'h0000);
    unlock(1'b1, 16'h2000);
    rd(CFG, 16'h0000);
    $display("test lock done");
    lf = nx(lf);
    y = bcd(int'(lf % 100));
    unlock(1'b0, 16'h2300);
    rd(CFG, 16'h2300);
    win(CFG, TIM, 16'h2300, '{{8'hff, y}, 16'h1231, 16'h0418, 16'h3759}, 0, 16'h2300,
        '{{8'h00, y}, 16'h1231, 16'h0418, 16'h3759, 16'h3759});
    rd(CFG, 16'h2000);
    tk(2 * SEC);
    rd(TIM, 16'h3759);
    win(ACF, AVL, 16'h0200, '{16'h0415, 16'h0210, 16'h0130, 16'h0000}, 0, 16'h0300,
        '{16'h0000, 16'h0415, 16'h0210, 16'h0000, 16'h0000});
    rd(ACF, 16'h0000);
    $display("test windows done");
    wr(CFG, 16'ha000);
    for (int i = 0; i < 2; i++)
    begin
      win(CFG, TIM, 16'ha300, '{{8'h00, yl[i]}, 16'h0228, 16'h0623, 16'h5959}, SEC + SEC / 4,
          16'ha300, '{{8'h00, yl[i]}, md[i], 16'h0000, 16'h0000, 16'h0000});
      rd(CFG, 16'ha000);
      tk(400);
      rd(CFG, 16'ha800);
      tk(200);
      rd(CFG, 16'hb800);
      rd(TIM, 16'h0000);
      rd(TIM, 16'h0000);
      wr(TIM, 16'h1000);
      rd(CFG, 16'ha000);
    end
    $display("test calendar done");
    wr(PAD, 16'h0002);
    wr(CFG, 16'ha400);
    wr(TIM, 16'h0000);
    tk(SEC / 4);
    chk(32'(pin_oe), 32'h1);
    chk(32'(pin_out), 32'h1);
    tk(SEC / 2);
    chk(32'(pin_out), 32'h0);
    wr(CFG, 16'ha000);
    tk(2);
    chk({31'h0, pin_oe, pin_out}, 32'h0);
    $display("test pin done");
    wr(PAD, 16'h0000);
    wr(CFG, 16'ha400);
    foreach (at[i])
    begin
      lf = nx(lf);
      c = {at[i], (i == 0 || i == 2) ? 8'h00 : lf[7:0]};
      wr(TIM, 16'h5959);
      wr(ACF, c);
      tk(SEC + SEC / 4);
      rd(ACF, aexp(c));
      chk(32'(pin_out), 32'(fire(c) != 0));
    end
    $display("test alarm done");
    // positive trim of 8 shortens the second after a minute wrap by 32 crystal edges
    wr(CFG, 16'ha008);
    wr(TIM, 16'h0059);
    tk(SEC * 15 / 8);
    rd(TIM, 16'h0101);
    wr(CFG, 16'h8000);
    bus(1'b0, CFG, 16'h0000);
    chk(q & 32'h0000a000, 32'h00008000);
    $display("test trim done");
    report_and_stop;
  end
endmodule : bcd_clock_calendar_ctrl_tb_top
`default_nettype wire
